/* design/pw_timers_pkg.sv */
// constants, register map and state codes for the discovery and repeat timers
package pw_timers_pkg;
  // clock: 10 MHz
  localparam int CLK_PERIOD_NS    = 100;
  // discovery unit 0.84 ms, debug period 102.4 ps held in tenths of ps
  localparam int DISC_UNIT_NS     = 840000;
  localparam int DISC_UNIT_CYCLES = DISC_UNIT_NS / CLK_PERIOD_NS;
  localparam int DISC_DBG_PS_X10  = 1024;
  localparam int CLK_PERIOD_PS_X10 = CLK_PERIOD_NS * 10000;
  localparam int DISC_DBG_RAW     =
    (DISC_DBG_PS_X10 + CLK_PERIOD_PS_X10 - 1) / CLK_PERIOD_PS_X10;
  localparam int DISC_DBG_CYCLES  = (DISC_DBG_RAW < 1) ? 1 : DISC_DBG_RAW;
  // repeat unit about 107 ms, debug window 0.82 to 1.64 us (least: round up)
  localparam int PW_UNIT_NS       = 107000000;
  localparam int PW_UNIT_CYCLES   = PW_UNIT_NS / CLK_PERIOD_NS;
  localparam int PW_DBG_NS        = 820;
  localparam int PW_DBG_CYCLES    =
    (PW_DBG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // counter width covers 15 repeat units
  localparam int CNT_W            = 24;
  // register byte offsets
  localparam logic [11:0] LINK_TIMER_CONTROL_OFS = 12'h000;
  localparam logic [11:0] IRQ_STATUS_OFS         = 12'h004;
  localparam logic [11:0] IRQ_MASK_OFS           = 12'h008;
  localparam logic [11:0] TIMER_STATE_OFS        = 12'h00C;
  localparam logic [11:0] ERROR_DETECT_OFS       = 12'h010;
  // link_timer_control fields
  localparam int DISC_CODE_LSB    = 28;
  localparam int PW_CODE_LSB      = 20;
  localparam logic [3:0] DISC_CODE_RST = 4'h9;
  localparam logic [3:0] PW_CODE_RST   = 4'h8;
  localparam logic [3:0] PW_CODE_OFF   = 4'h0;
  localparam logic [3:0] PW_CODE_DBG   = 4'hF;
  localparam logic [3:0] DISC_CODE_DBG = 4'h0;
  // interrupt bits
  localparam int IRQ_N            = 2;
  localparam int IRQ_DISC_DONE    = 0;
  localparam int IRQ_PW_SENT      = 1;
  // state codes, one-hot
  typedef enum logic [1:0] {
    disc_idle = 2'b01,
    disc_run  = 2'b10
  } disc_state_e;
  typedef enum logic [1:0] {
    pw_idle = 2'b01,
    pw_wait = 2'b10
  } pw_state_e;
endpackage : pw_timers_pkg

/* design/discovery_timer.sv */
// link-discovery wait timer
`timescale 1ns/1ns
module discovery_timer
  import pw_timers_pkg::*;
#(
  parameter int UNIT_CYCLES = DISC_UNIT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       start,
  input  wire logic [3:0] code,
  output logic            active_q,
  output logic            done_q
);
  disc_state_e      state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] load_w;
  logic             last_w;

  // code zero gives the shortest wait the clock allows
  assign load_w = (code == DISC_CODE_DBG) ? CNT_W'(DISC_DBG_CYCLES)
                : CNT_W'(code) * CNT_W'(UNIT_CYCLES);
  assign last_w = (state_q == disc_run) && (cnt_q == CNT_W'(1));

  // restart on a fresh start even while running
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= disc_idle;
      cnt_q   <= '0;
      done_q  <= 1'b0;
    end else begin
      done_q <= last_w && !start;
      case (state_q)
        disc_idle: begin
          if (start) begin
            state_q <= disc_run;
            cnt_q   <= load_w;
          end
        end
        disc_run: begin
          if (start) begin
            cnt_q <= load_w;
          end else if (last_w) begin
            state_q <= disc_idle;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        default: state_q <= disc_idle;
      endcase
    end
  end

  // active mirrors the running state as a flop of its own
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) active_q <= 1'b0;
    else active_q <= start || ((state_q == disc_run) && !last_w);
  end
endmodule : discovery_timer

/* design/pw_repeat_timer.sv */
// error-report port-write repeat timer
`timescale 1ns/1ns
module pw_repeat_timer
  import pw_timers_pkg::*;
#(
  parameter int UNIT_CYCLES = PW_UNIT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       error_event,
  input  wire logic       service,
  input  wire logic [3:0] code,
  output logic            send_q,
  output logic            waiting_q
);
  pw_state_e        state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] load_w;
  logic             expire_w;
  logic             first_w;

  // window start is code times the unit, debug code F excepted; reserved codes scale alike
  assign load_w = (code == PW_CODE_DBG) ? CNT_W'(PW_DBG_CYCLES)
                : CNT_W'(code) * CNT_W'(UNIT_CYCLES);
  assign expire_w = (state_q == pw_wait) && (cnt_q == CNT_W'(1))
                  && !service;
  assign first_w  = (state_q == pw_idle) && error_event && !service;

  // service beats expiry in the same cycle, so no stray resend
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= pw_idle;
      cnt_q   <= '0;
      send_q  <= 1'b0;
    end else begin
      send_q <= first_w || expire_w;
      case (state_q)
        pw_idle: begin
          if (first_w && (code != PW_CODE_OFF)) begin
            state_q <= pw_wait;
            cnt_q   <= load_w;
          end
        end
        pw_wait: begin
          if (service) begin
            state_q <= pw_idle;
          end else if (expire_w) begin
            cnt_q <= load_w;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        default: state_q <= pw_idle;
      endcase
    end
  end

  // armed flag rises with the first send unless the code is off, so a stray error is not taken while armed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) waiting_q <= 1'b0;
    else waiting_q <= ((state_q == pw_wait) && !service)
                   || (first_w && (code != PW_CODE_OFF));
  end
endmodule : pw_repeat_timer

/* design/port_discovery_pw_timers.sv */
// apb register front end with discovery and port-write repeat timers
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module port_discovery_pw_timers
  import pw_timers_pkg::*;
#(
  parameter int DISC_UNIT = DISC_UNIT_CYCLES,
  parameter int PW_UNIT   = PW_UNIT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        discovery_start,
  input  wire logic        error_report,
  output logic             discovery_active,
  output logic             discovery_done,
  output logic             pw_send,
  output logic             pw_repeating,
  output logic             irq
);
  logic [3:0]       disc_code_q;
  logic [3:0]       pw_code_q;
  logic [IRQ_N-1:0] irq_status_q;
  logic [IRQ_N-1:0] irq_mask_q;
  logic [IRQ_N-1:0] irq_event_w;
  logic [31:0]      prdata_q;
  logic [31:0]      rdata_w;
  logic             pready_q;
  logic             pslverr_q;
  logic             irq_q;
  logic             setup_w;
  logic             access_w;
  logic             wr_w;
  logic             hit_ltc_w;
  logic             hit_sts_w;
  logic             hit_msk_w;
  logic             hit_tst_w;
  logic             hit_err_w;
  logic             mapped_w;
  logic             service_w;
  logic             disc_active_w;
  logic             disc_done_w;
  logic             pw_send_w;
  logic             pw_wait_w;

  // bus phase decode; pready is a flop set in the setup cycle, so no wait state
  assign setup_w   = psel && !penable && !pready_q;
  assign access_w  = psel && penable && pready_q;
  assign wr_w      = access_w && pwrite;
  assign hit_ltc_w = (paddr == LINK_TIMER_CONTROL_OFS);
  assign hit_sts_w = (paddr == IRQ_STATUS_OFS);
  assign hit_msk_w = (paddr == IRQ_MASK_OFS);
  assign hit_tst_w = (paddr == TIMER_STATE_OFS);
  assign hit_err_w = (paddr == ERROR_DETECT_OFS);
  assign mapped_w  = hit_ltc_w || hit_sts_w || hit_msk_w
                   || hit_tst_w || hit_err_w;
  // any write to the error-detect word counts as servicing
  assign service_w = wr_w && hit_err_w;

  // read mux; reserved fields read zero
  assign rdata_w =
      hit_ltc_w ? {disc_code_q, 4'h0, pw_code_q, 20'h00000}
    : hit_sts_w ? {{(32-IRQ_N){1'b0}}, irq_status_q}
    : hit_msk_w ? {{(32-IRQ_N){1'b0}}, irq_mask_q}
    : hit_tst_w ? {30'h00000000, pw_wait_w, disc_active_w}
    : 32'h00000000;

  // apb answer: ready and data registered in the setup cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup_w;
      pslverr_q <= setup_w && !mapped_w;
      if (setup_w) prdata_q <= pwrite ? 32'h00000000 : rdata_w;
    end
  end

  // timer codes, written only at the access edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      disc_code_q <= DISC_CODE_RST;
      pw_code_q   <= PW_CODE_RST;
    end else if (wr_w && hit_ltc_w) begin
      disc_code_q <= pwdata[DISC_CODE_LSB +: 4];
      pw_code_q   <= pwdata[PW_CODE_LSB +: 4];
    end
  end

  // mask register, same layout as status
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) irq_mask_q <= '0;
    else if (wr_w && hit_msk_w) irq_mask_q <= pwdata[IRQ_N-1:0];
  end

  assign irq_event_w[IRQ_DISC_DONE] = disc_done_w;
  assign irq_event_w[IRQ_PW_SENT]   = pw_send_w;

  // sticky status, write one to clear; a same-cycle event wins
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_N; gi++) begin : g_irq
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          irq_status_q[gi] <= 1'b0;
        end else if (irq_event_w[gi]) begin
          irq_status_q[gi] <= 1'b1;
        end else if (wr_w && hit_sts_w && pwdata[gi]) begin
          irq_status_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // level interrupt lags the status by one edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) irq_q <= 1'b0;
    else irq_q <= |(irq_status_q & irq_mask_q);
  end

  discovery_timer #(
    .UNIT_CYCLES (DISC_UNIT)
  ) u_disc (
    .clk      (clk),
    .resetn   (resetn),
    .start    (discovery_start),
    .code     (disc_code_q),
    .active_q (disc_active_w),
    .done_q   (disc_done_w)
  );

  pw_repeat_timer #(
    .UNIT_CYCLES (PW_UNIT)
  ) u_pw (
    .clk         (clk),
    .resetn      (resetn),
    .error_event (error_report),
    .service     (service_w),
    .code        (pw_code_q),
    .send_q      (pw_send_w),
    .waiting_q   (pw_wait_w)
  );

  // outputs straight from flops
  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign irq              = irq_q;
  assign discovery_active = disc_active_w;
  assign discovery_done   = disc_done_w;
  assign pw_send          = pw_send_w;
  assign pw_repeating     = pw_wait_w;
endmodule : port_discovery_pw_timers

/* bench/timer_properties.sv */
// port-level assertions for the discovery and port-write timers
`timescale 1ns/1ns
module timer_properties
  import pw_timers_pkg::*;
#(
  parameter int DISC_UNIT = 4,
  parameter int PW_UNIT   = 8
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        discovery_start,
  input wire logic        discovery_done,
  input wire logic        discovery_active,
  input wire logic        error_report,
  input wire logic        pw_send,
  input wire logic        pw_repeating
);
  logic [3:0] dcode_q;
  logic [3:0] pcode_q;
  // completed apb writes to the control and error-detect words
  wire wr_ctl = psel && penable && pready && pwrite &&
                paddr == LINK_TIMER_CONTROL_OFS;
  wire svc    = psel && penable && pready && pwrite &&
                paddr == ERROR_DETECT_OFS;
  // mirror of the two code fields, repeat counts assume units 4 and 8
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dcode_q <= DISC_CODE_RST;
      pcode_q <= PW_CODE_RST;
    end else if (wr_ctl) begin
      dcode_q <= pwdata[31:28];
      pcode_q <= pwdata[23:20];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_start_active;
    discovery_start |=> discovery_active;
  endproperty
  a_start_active: assert property (p_start_active)
    else $error("discovery not active after start");
  property p_disc_dbg;
    discovery_start && dcode_q == 4'h0 ##1 !discovery_start
      |=> discovery_done;
  endproperty
  a_disc_dbg: assert property (p_disc_dbg)
    else $error("debug discovery wait wrong");
  property p_disc_unit;
    discovery_start && dcode_q == 4'h1 ##1 (!discovery_start)[*4]
      |=> discovery_done;
  endproperty
  a_disc_unit: assert property (p_disc_unit)
    else $error("one-unit discovery wait wrong");
  property p_pw_first;
    error_report && !pw_repeating && !svc |=> pw_send;
  endproperty
  a_pw_first: assert property (p_pw_first)
    else $error("no port-write after error");
  property p_service;
    svc |=> !pw_repeating && !pw_send;
  endproperty
  a_service: assert property (p_service)
    else $error("repeat not stopped by service");
  property p_once;
    pw_send && pcode_q == 4'h0 |=> (!pw_send || $past(error_report))[*8];
  endproperty
  a_once: assert property (p_once)
    else $error("port-write repeated with code zero");
  property p_dbg_rep;
    pw_send && pcode_q == 4'hF |=> (!pw_send)[*8] ##1
      (pw_send || !pw_repeating);
  endproperty
  a_dbg_rep: assert property (p_dbg_rep)
    else $error("debug repeat period wrong");
  property p_unit_rep;
    pw_send && pcode_q == 4'h1 |=> (!pw_send)[*7] ##1
      (pw_send || !pw_repeating);
  endproperty
  a_unit_rep: assert property (p_unit_rep)
    else $error("one-unit repeat period wrong");
endmodule : timer_properties

/* bench/link_partner.sv */
// link partner model: starts discovery, reports errors, counts port-writes
`timescale 1ns/1ns
module link_partner (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic disc_req,
  input  wire logic err_req,
  input  wire logic pw_send,
  output logic      discovery_start,
  output logic      error_report,
  output int        pw_seen
);
  // registered one-cycle requests and a running port-write count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      discovery_start <= 1'b0;
      error_report    <= 1'b0;
      pw_seen         <= 0;
    end else begin
      discovery_start <= disc_req;
      error_report    <= err_req;
      pw_seen         <= pw_seen + int'(pw_send);
    end
  end
endmodule : link_partner

/* bench/tb.sv */
// self-checking bench for the discovery and port-write timers
`timescale 1ns/1ns
module tb;
  import pw_timers_pkg::*;
  logic        clk, resetn, psel, penable, pwrite, disc_req, err_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, se, discovery_start, error_report;
  logic        discovery_active, discovery_done, pw_send, pw_repeating;
  logic        irq;
  logic [3:0]  c;
  logic [3:0]  pc [5] = '{4'hF, 4'h1, 4'h2, 4'h4, 4'h8};
  int          err_total, compares, seed, cyc, i, k, t0, t1, t2, pw_seen;
  port_discovery_pw_timers #(.DISC_UNIT(4), .PW_UNIT(8)) i_dut (
    .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .discovery_start, .error_report,
    .discovery_active, .discovery_done, .pw_send, .pw_repeating, .irq);
  link_partner i_partner (.clk, .resetn, .disc_req, .err_req, .pw_send,
    .discovery_start, .error_report, .pw_seen);
  // clock and cycle count
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  function int dwait(input logic [3:0] c);
    return (c == 4'h0) ? 2 : c * 4 + 1;
  endfunction : dwait
  function int pgap(input logic [3:0] c);
    return (c == 4'hF) ? 9 : c * 8;
  endfunction : pgap
  task summarize();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // pick one watched output by index
  function automatic logic pick(input int sel);
    case (sel)
      0: return discovery_start;
      1: return discovery_done;
      2: return error_report;
      default: return pw_send;
    endcase
  endfunction : pick
  // bounded wait for a high sample; cycle stamp of that edge returned
  task automatic wait_sig(input int sel, output int t);
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (pick(sel) === 1'b1) break;
    end
    t = cyc;
    if (n == 200) begin
      err_total++;
      summarize();
    end
  endtask : wait_sig
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      err_total++;
      summarize();
    end
  endtask : apb
  task pulse(input logic e);
    disc_req <= !e;
    err_req <= e;
    @(posedge clk);
    disc_req <= 1'b0;
    err_req <= 1'b0;
  endtask : pulse
  // main sequence: reset values, fields, refusals, timers, interrupt
  initial begin
    {psel, penable, pwrite, disc_req, err_req, resetn} = '0;
    {paddr, pwdata} = '0;
    {err_total, compares} = '0;
    seed = 32'hEDAB;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    apb(LINK_TIMER_CONTROL_OFS, 1'b0, 32'h0);
    check("control reset", rd, 32'h9080_0000);
    for (i = 0; i < 4; i++) begin
      t0 = $random(seed);
      apb(LINK_TIMER_CONTROL_OFS, 1'b1, t0);
      apb(LINK_TIMER_CONTROL_OFS, 1'b0, 32'h0);
      check("control field", rd, t0 & 32'hF0F0_0000);
    end
    apb(12'h014, 1'b0, 32'h0);
    check("unmapped err", se, 1'b1);
    check("unmapped data", rd, 32'h0);
    for (i = 0; i < 3; i++) begin
      c = (i < 2) ? 4'(i) : 4'(2 + ($random(seed) & 1));
      apb(LINK_TIMER_CONTROL_OFS, 1'b1, {c, 28'h0});
      pulse(1'b0);
      wait_sig(0, t0);
      wait_sig(1, t1);
      check("discovery wait", t1 - t0, dwait(c));
      if (i == 0)
        check("irq masked", irq, 1'b0);
      apb(IRQ_MASK_OFS, 1'b1, 32'h3);
    end
    apb(IRQ_STATUS_OFS, 1'b0, 32'h0);
    check("status done", rd[IRQ_DISC_DONE], 1'b1);
    check("irq raised", irq, 1'b1);
    apb(IRQ_STATUS_OFS, 1'b1, 32'h1);
    apb(IRQ_STATUS_OFS, 1'b0, 32'h0);
    check("status cleared", rd, 32'h0);
    check("irq cleared", irq, 1'b0);
    for (i = 0; i < 5; i++) begin
      apb(LINK_TIMER_CONTROL_OFS, 1'b1, {8'h10, pc[i], 20'h0});
      pulse(1'b1);
      wait_sig(2, t0);
      wait_sig(3, t1);
      check("first send", t1 - t0, 1);
      wait_sig(3, t2);
      check("repeat gap", t2 - t1, pgap(pc[i]));
      wait_sig(3, t0);
      check("second gap", t0 - t2, pgap(pc[i]));
      apb(ERROR_DETECT_OFS, 1'b1, $random(seed));
      apb(TIMER_STATE_OFS, 1'b0, 32'h0);
      check("repeat stopped", rd[1], 1'b0);
      k = pw_seen;
      repeat (40) @(posedge clk);
      check("no send after service", pw_seen, k);
    end
    apb(IRQ_STATUS_OFS, 1'b0, 32'h0);
    check("status sent", rd[IRQ_PW_SENT], 1'b1);
    apb(LINK_TIMER_CONTROL_OFS, 1'b1, 32'h1000_0000);
    k = pw_seen;
    pulse(1'b1);
    repeat (40) @(posedge clk);
    check("single send", pw_seen, k + 1);
    apb(ERROR_DETECT_OFS, 1'b1, 32'h1);
    summarize();
  end
endmodule : tb
bind port_discovery_pw_timers timer_properties #(.DISC_UNIT(DISC_UNIT),
  .PW_UNIT(PW_UNIT)) i_props (.clk, .resetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .discovery_start, .discovery_done,
  .discovery_active, .error_report, .pw_send, .pw_repeating);
